// File: ocd_regs.sv
// Function
// - Swing trim in bits 5:4 selects 0.8 to 1.1 V, resets to 10.
// - Bit 3 enables on-chip termination, resets to 0.
// - Bit 2 enables regulator, resets 1; bit 1 enables driver, resets 0.
// - Writing 1 to bit 0 clears the channel divider; bit self-clears.
// - The divider clear acts at once, without the update strobe.
// - Divide-ratio code 0x01 to 0xff divides by that value.
// - Divide-ratio code zero disables the channel divider.
// - Divide-ratio registers reset to 0x01, dividing by one.
// - Buffered writes reach active controls only on update bit 0 write.
`timescale 1ns/1ps

module ocd_regs
  import ocd_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Register access from the serial control port deserialiser
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic [7:0]      regRdata,
  output logic            regRdValid,
  // Divided VCO clock, one enable per edge to count
  input  wire logic       vcoTick,
  // Active driver settings
  output ocd_drive_t      ch1Drive,
  output ocd_drive_t      ch2Drive,
  // Divider clears for channels whose dividers sit elsewhere or here
  output logic            ch1DividerClear,
  output logic            ch2DividerClear,
  // Divided channel outputs
  output logic            ch2DivOut,
  output logic            ch3DivOut
);

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  ocd_req_t req;

  assign req.write = regWrite;
  assign req.read  = regRead;
  assign req.addr  = regAddr;
  assign req.wdata = regWdata;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire logic hitUpdate  = (req.addr == OCD_OFS_UPDATE);
  wire logic hitCh1Drv  = (req.addr == OCD_OFS_CH1_DRIVE);
  wire logic hitCh2Div  = (req.addr == OCD_OFS_CH2_DIVIDE);
  wire logic hitCh2Drv  = (req.addr == OCD_OFS_CH2_DRIVE);
  wire logic hitCh3Div  = (req.addr == OCD_OFS_CH3_DIVIDE);

  wire logic wrUpdate   = req.write && hitUpdate;
  wire logic wrCh1Drv   = req.write && hitCh1Drv;
  wire logic wrCh2Div   = req.write && hitCh2Div;
  wire logic wrCh2Drv   = req.write && hitCh2Drv;
  wire logic wrCh3Div   = req.write && hitCh3Div;

  // The update bit is live: it is never stored, only acted upon.
  wire logic doUpdate   = wrUpdate && req.wdata[OCD_BIT_UPDATE];

  // ----------------------------------------------------------------------
  // Buffer registers, loaded by host writes
  // ----------------------------------------------------------------------
  ocd_drive_t ch1DriveBuf_r;
  ocd_drive_t ch2DriveBuf_r;
  logic [7:0] ch2DivideBuf_r;
  logic [7:0] ch3DivideBuf_r;

  // Reserved bits 7:6 are dropped; the host keeps them at zero.
  wire ocd_drive_t ch1DriveIn = ocd_byte_to_drive(req.wdata);
  wire ocd_drive_t ch2DriveIn = ocd_byte_to_drive(req.wdata);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ch1DriveBuf_r  <= ocd_byte_to_drive(OCD_RST_DRIVE);
      ch2DriveBuf_r  <= ocd_byte_to_drive(OCD_RST_DRIVE);
      ch2DivideBuf_r <= OCD_RST_DIVIDE;
      ch3DivideBuf_r <= OCD_RST_DIVIDE;
    end else begin
      if (wrCh1Drv) begin
        ch1DriveBuf_r <= ch1DriveIn;
      end
      if (wrCh2Drv) begin
        ch2DriveBuf_r <= ch2DriveIn;
      end
      if (wrCh2Div) begin
        ch2DivideBuf_r <= req.wdata;
      end
      if (wrCh3Div) begin
        ch3DivideBuf_r <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Active control registers, loaded only by the update strobe
  // ----------------------------------------------------------------------
  logic [7:0] ch2Divide_r;
  logic [7:0] ch3Divide_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ch1Drive    <= ocd_byte_to_drive(OCD_RST_DRIVE);
      ch2Drive    <= ocd_byte_to_drive(OCD_RST_DRIVE);
      ch2Divide_r <= OCD_RST_DIVIDE;
      ch3Divide_r <= OCD_RST_DIVIDE;
    end else if (doUpdate) begin
      ch1Drive    <= ch1DriveBuf_r;
      ch2Drive    <= ch2DriveBuf_r;
      ch2Divide_r <= ch2DivideBuf_r;
      ch3Divide_r <= ch3DivideBuf_r;
    end
  end

  // ----------------------------------------------------------------------
  // Live divider clears
  // ----------------------------------------------------------------------
  // The clear bypasses the buffer so that a host can realign phase
  // without an update; the same write still loads the other bits into the drive buffer.
  wire logic clr1Nxt = wrCh1Drv && req.wdata[OCD_BIT_DIV_CLEAR];
  wire logic clr2Nxt = wrCh2Drv && req.wdata[OCD_BIT_DIV_CLEAR];

  always_ff @(posedge mclk) begin
    if (rst) begin
      ch1DividerClear <= 1'b0;
      ch2DividerClear <= 1'b0;
    end else begin
      ch1DividerClear <= clr1Nxt;
      ch2DividerClear <= clr2Nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Channel dividers
  // ----------------------------------------------------------------------
  // The channel 3 divider has no clear; its clear input is tied low.
  ocd_chan_divider u_ch2_div (
    .mclk        (mclk),
    .rst         (rst),
    .tick        (vcoTick),
    .divideValue (ch2Divide_r),
    .clear       (ch2DividerClear),
    .divOut      (ch2DivOut)
  );

  ocd_chan_divider u_ch3_div (
    .mclk        (mclk),
    .rst         (rst),
    .tick        (vcoTick),
    .divideValue (ch3Divide_r),
    .clear       (1'b0),
    .divOut      (ch3DivOut)
  );

  // ----------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------
  // Reads show the buffer, which is what the host last wrote; the clear
  // and update bits always read as zero.
  wire logic [7:0] rdMux =
      hitCh1Drv ? ocd_drive_to_byte(ch1DriveBuf_r) :
      hitCh2Drv ? ocd_drive_to_byte(ch2DriveBuf_r) :
      hitCh2Div ? ch2DivideBuf_r :
      hitCh3Div ? ch3DivideBuf_r :
                  OCD_RD_UNMAPPED;

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata   <= OCD_RD_UNMAPPED;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= req.read;
      if (req.read) begin
        regRdata <= rdMux;
      end
    end
  end

endmodule // ocd_regs

// File: ocd_pkg.sv
package ocd_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          OCD_ADDR_W          = 12;
  localparam logic [11:0] OCD_OFS_UPDATE      = 12'h00f;
  localparam logic [11:0] OCD_OFS_CH1_DRIVE   = 12'h015;
  localparam logic [11:0] OCD_OFS_CH2_DIVIDE  = 12'h016;
  localparam logic [11:0] OCD_OFS_CH2_DRIVE   = 12'h017;
  localparam logic [11:0] OCD_OFS_CH3_DIVIDE  = 12'h018;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OCD_BIT_UPDATE      = 0;
  localparam int OCD_BIT_TRIM_HI     = 5;
  localparam int OCD_BIT_TRIM_LO     = 4;
  localparam int OCD_BIT_TERM        = 3;
  localparam int OCD_BIT_REGULATOR   = 2;
  localparam int OCD_BIT_DRIVER      = 1;
  localparam int OCD_BIT_DIV_CLEAR   = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] OCD_RST_DRIVE  = 8'h24;
  localparam logic [7:0] OCD_RST_DIVIDE = 8'h01;
  localparam logic [7:0] OCD_DIV_OFF    = 8'h00;
  localparam logic [7:0] OCD_RD_UNMAPPED = 8'h00;

  // Swing trim codes: 0.8 V, 0.9 V, 1.0 V, 1.1 V.
  localparam logic [1:0] OCD_TRIM_0V8 = 2'h0;
  localparam logic [1:0] OCD_TRIM_0V9 = 2'h1;
  localparam logic [1:0] OCD_TRIM_1V0 = 2'h2;
  localparam logic [1:0] OCD_TRIM_1V1 = 2'h3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] swingTrim;
    logic       terminationOn;
    logic       regulatorOn;
    logic       driverOn;
  } ocd_drive_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } ocd_req_t;

  typedef enum {OCD_DIV_IDLE, OCD_DIV_RUN} ocd_div_state_t;

  // Reserved bits 7:6 and the live clear bit 0 read back as zero.
  function automatic logic [7:0] ocd_drive_to_byte(input ocd_drive_t d);
    logic [7:0] b;
    b = 8'h00;
    b[OCD_BIT_TRIM_HI:OCD_BIT_TRIM_LO] = d.swingTrim;
    b[OCD_BIT_TERM]      = d.terminationOn;
    b[OCD_BIT_REGULATOR] = d.regulatorOn;
    b[OCD_BIT_DRIVER]    = d.driverOn;
    return b;
  endfunction

  function automatic ocd_drive_t ocd_byte_to_drive(input logic [7:0] b);
    ocd_drive_t d;
    d.swingTrim     = b[OCD_BIT_TRIM_HI:OCD_BIT_TRIM_LO];
    d.terminationOn = b[OCD_BIT_TERM];
    d.regulatorOn   = b[OCD_BIT_REGULATOR];
    d.driverOn      = b[OCD_BIT_DRIVER];
    return d;
  endfunction

endpackage

// File: ocd_chan_divider.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Channel divider: one output pulse every divideValue input ticks.
// ------------------------------------------------------------------------
module ocd_chan_divider
  import ocd_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Control
  input  wire logic       tick,
  input  wire logic [7:0] divideValue,
  input  wire logic       clear,
  // Result
  output logic            divOut
);

  ocd_div_state_t state_r;
  ocd_div_state_t state_nxt;
  logic [7:0]     count_r;
  logic [7:0]     count_nxt;
  logic           divOut_nxt;

  wire logic       divOff   = (divideValue == OCD_DIV_OFF);
  wire logic [7:0] lastCnt  = divideValue - 8'h01;
  wire logic       wrapNow  = tick && (count_r >= lastCnt);

  always_comb begin
    state_nxt  = state_r;
    count_nxt  = count_r;
    divOut_nxt = 1'b0;
    case (state_r)
      OCD_DIV_IDLE: begin
        count_nxt = 8'h00;
        if (!divOff) begin
          state_nxt = OCD_DIV_RUN;
        end
      end
      OCD_DIV_RUN: begin
        if (divOff) begin
          state_nxt = OCD_DIV_IDLE;
          count_nxt = 8'h00;
        end else if (wrapNow) begin
          count_nxt  = 8'h00;
          divOut_nxt = 1'b1;
        end else if (tick) begin
          count_nxt = count_r + 8'h01;
        end
      end
      default: begin
        state_nxt = OCD_DIV_IDLE;
        count_nxt = 8'h00;
      end
    endcase
    // A clear restarts the count so the phase is known once it ends.
    if (clear) begin
      state_nxt  = OCD_DIV_IDLE;
      count_nxt  = 8'h00;
      divOut_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= OCD_DIV_IDLE;
      count_r <= 8'h00;
      divOut  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      divOut  <= divOut_nxt;
    end
  end

endmodule // ocd_chan_divider

// File: ocd_regs_monitor.sv
`timescale 1ns/1ps

module ocd_regs_monitor
  import ocd_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic [7:0]  regRdata,
  input  wire logic        regRdValid,
  // Channel side
  input  wire logic        vcoTick,
  input  wire ocd_drive_t  ch1Drive,
  input  wire ocd_drive_t  ch2Drive,
  input  wire logic        ch1DividerClear,
  input  wire logic        ch2DividerClear,
  input  wire logic        ch2DivOut,
  input  wire logic        ch3DivOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence clr1Wr;
    regWrite && regAddr == OCD_OFS_CH1_DRIVE && regWdata[0];
  endsequence
  sequence clr2Wr;
    regWrite && regAddr == OCD_OFS_CH2_DRIVE && regWdata[0];
  endsequence

  chk_clear1_live: assert property (clr1Wr |=> ch1DividerClear)
    else $error("ch1 clear late");
  chk_clear2_live: assert property (clr2Wr |=> ch2DividerClear)
    else $error("ch2 clear late");
  chk_clear1_cause: assert property (ch1DividerClear
    |-> $past(regWrite && regAddr == OCD_OFS_CH1_DRIVE && regWdata[OCD_BIT_DIV_CLEAR]))
    else $error("ch1 clear uncaused");
  chk_clear2_cause: assert property (ch2DividerClear
    |-> $past(regWrite && regAddr == OCD_OFS_CH2_DRIVE && regWdata[OCD_BIT_DIV_CLEAR]))
    else $error("ch2 clear uncaused");
  chk_drive_held: assert property ($changed({ch1Drive, ch2Drive})
    |-> $past(regWrite && regAddr == OCD_OFS_UPDATE && regWdata[OCD_BIT_UPDATE]))
    else $error("drive moved early");
  chk_reset_drive: assert property ($fell(rst)
    |-> ch1Drive == 5'h12 && ch2Drive == 5'h12) else $error("drive reset value");
  chk_unmapped_read: assert property (regRead && regAddr == 12'h000
    |=> regRdValid && regRdata == OCD_RD_UNMAPPED) else $error("unmapped read");
  chk_pulse_tick: assert property ((ch2DivOut || ch3DivOut) |-> $past(vcoTick))
    else $error("pulse without tick");
endmodule // ocd_regs_monitor

bind ocd_regs ocd_regs_monitor i_mon (.mclk(mclk), .rst(rst), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .regRdValid(regRdValid), .vcoTick(vcoTick), .ch1Drive(ch1Drive), .ch2Drive(ch2Drive),
  .ch1DividerClear(ch1DividerClear), .ch2DividerClear(ch2DividerClear),
  .ch2DivOut(ch2DivOut), .ch3DivOut(ch3DivOut));

// File: ocd_host.sv
`timescale 1ns/1ps

module ocd_host
  import ocd_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Register port
  output logic             regWrite,
  output logic             regRead,
  output logic [11:0]      regAddr,
  output logic [7:0]       regWdata,
  input  wire logic [7:0]  regRdata,
  input  wire logic        regRdValid
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 12'h000;
    regWdata = 8'h00;
  end

  // Released address and data lines show the inverse, never the last value.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = (a == OCD_OFS_CH1_DRIVE || a == OCD_OFS_CH2_DRIVE) ? (d & 8'h3f) : d;
    @(posedge mclk);
    #1;
    regWrite = 1'b0;
    regAddr  = ~a;
    regWdata = ~regWdata;
  endtask

  task automatic upd();
    wr(OCD_OFS_UPDATE, 8'h01);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    int k;
    @(posedge mclk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge mclk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    // The answer stands for one cycle after the taking edge, so it is
    // looked at 1 ns into that cycle, clear of the edge that launches it.
    k = 0;
    while (regRdValid !== 1'b1 && k < 8) begin
      @(posedge mclk);
      #1;
      k++;
    end
    d = (regRdValid === 1'b1) ? regRdata : 8'hxx;
  endtask
endmodule // ocd_host

// File: output_channel_divider_regs_tb_top.sv
`timescale 1ns/1ps

module output_channel_divider_regs_tb_top;
  import ocd_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        vcoTick = 1'b0;
  logic        selCh3 = 1'b0;
  logic        regWrite, regRead, regRdValid;
  logic [11:0] regAddr;
  logic [7:0]  regWdata, regRdata, d;
  ocd_drive_t  ch1Drive, ch2Drive;
  logic        ch1DividerClear, ch2DividerClear, ch2DivOut, ch3DivOut;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n, m;
  wire         pulse = selCh3 ? ch3DivOut : ch2DivOut;

  always #5 mclk = ~mclk;

  ocd_host i_host (.mclk(mclk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid));
  ocd_regs i_dut (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .vcoTick(vcoTick), .ch1Drive(ch1Drive), .ch2Drive(ch2Drive),
    .ch1DividerClear(ch1DividerClear), .ch2DividerClear(ch2DividerClear),
    .ch2DivOut(ch2DivOut), .ch3DivOut(ch3DivOut));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cycles between two divider pulses, with the tick held high.
  task automatic span(output int c);
    c = 0;
    do begin @(posedge mclk); #1; c++; end while (pulse !== 1'b1 && c < 600);
    c = 0;
    do begin @(posedge mclk); #1; c++; end while (pulse !== 1'b1 && c < 600);
  endtask

  task automatic setDiv(input logic [11:0] a, input logic [7:0] v);
    i_host.wr(a, v);
    i_host.upd();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic t_reset();
    i_host.rd(OCD_OFS_CH1_DRIVE, d); chk(d, 8'h24);
    i_host.rd(OCD_OFS_CH2_DRIVE, d); chk(d, 8'h24);
    i_host.rd(OCD_OFS_CH2_DIVIDE, d); chk(d, 8'h01);
    i_host.rd(OCD_OFS_CH3_DIVIDE, d); chk(d, 8'h01);
    i_host.rd(12'h000, d); chk(d, 8'h00);
    chk({3'h0, ch1Drive}, 8'h12);
    selCh3 = 1'b1;
    span(n); chk(n[7:0], 8'h01);
  endtask

  task automatic t_buffered();
    selCh3 = 1'b0;
    i_host.wr(OCD_OFS_CH2_DIVIDE, 8'h03);
    i_host.wr(OCD_OFS_CH1_DRIVE, 8'hfa);
    i_host.rd(OCD_OFS_CH1_DRIVE, d); chk(d, 8'h3a);
    chk({3'h0, ch1Drive}, 8'h12);
    span(n); chk(n[7:0], 8'h01);
    setDiv(OCD_OFS_UPDATE, 8'h01);
    chk({3'h0, ch1Drive}, 8'h1d);
    span(n); chk(n[7:0], 8'h03);
  endtask

  task automatic t_trim();
    for (int c = 0; c < 4; c++) begin
      setDiv(OCD_OFS_CH2_DRIVE, {2'h3, c[1:0], 4'h6});
      chk({3'h0, ch2Drive}, {3'h0, c[1:0], 3'h3});
    end
  endtask

  task automatic t_ratios();
    setDiv(OCD_OFS_CH2_DIVIDE, 8'h02);
    span(n); chk(n[7:0], 8'h02);
    setDiv(OCD_OFS_CH2_DIVIDE, 8'hff);
    span(n); chk(n[7:0], 8'hff);
    selCh3 = 1'b1;
    setDiv(OCD_OFS_CH3_DIVIDE, 8'h00);
    m = 0;
    repeat (300) begin @(posedge mclk); m += int'(pulse === 1'b1); end
    chk(m[7:0], 8'h00);
    setDiv(OCD_OFS_CH3_DIVIDE, 8'h05);
    span(n); chk(n[7:0], 8'h05);
    selCh3 = 1'b0;
  endtask

  task automatic t_clear();
    setDiv(OCD_OFS_CH2_DIVIDE, 8'h04);
    for (int r = 0; r < 2; r++) begin
      repeat (r + 1) @(posedge mclk);
      i_host.wr(OCD_OFS_CH2_DRIVE, 8'h25);
      chk({7'h0, ch2DividerClear}, 8'h01);
      chk({3'h0, ch2Drive}, 8'h1b);
      m = 0;
      do begin @(posedge mclk); #1; m++; end while (ch2DivOut !== 1'b1 && m < 50);
      if (r == 0) n = m;
    end
    chk(m[7:0], n[7:0]);
    i_host.rd(OCD_OFS_CH2_DRIVE, d); chk(d, 8'h24);
    i_host.wr(OCD_OFS_CH1_DRIVE, 8'h3b);
    chk({7'h0, ch1DividerClear}, 8'h01);
    vcoTick = 1'b0;
    m = 0;
    repeat (20) begin @(posedge mclk); #1; m += int'(ch2DivOut === 1'b1); end
    chk(m[7:0], 8'h00);
    vcoTick = 1'b1;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    vcoTick = 1'b1;
    t_reset();
    t_buffered();
    t_trim();
    t_ratios();
    t_clear();
    summarize();
  end
endmodule // output_channel_divider_regs_tb_top
